// ### rtl/cic_pkg.sv
// Shared constants and types for the fifth-order interpolator block
package cic_pkg;
  // Sample width from the coefficient filter and towards the tuner
  localparam int SAMPLE_W = 16;
  // Accumulator growth margin: 4*log2(32) gain bits plus peaking headroom
  localparam int GROWTH_W = 25;
  localparam int ACC_W = SAMPLE_W + GROWTH_W;
  // Number of integrator and comb sections
  localparam int ORDER = 5;
  // Buffer in front of the filter
  localparam int FIFO_DEPTH = 32;
  // Channel register offsets (low byte of the channel address)
  localparam logic [7:0] SHIFT_OFS = 8'h06;
  localparam logic [7:0] FACTOR_OFS = 8'h09;
  // Register widths and reset values
  localparam int SHIFT_W = 6;
  localparam int FACTOR_W = 8;
  localparam logic [SHIFT_W-1:0] SHIFT_RST = 6'h00;
  localparam logic [FACTOR_W-1:0] FACTOR_RST = 8'h00;
  // Complex sample carried through the block
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } cic_iq_s;
endpackage : cic_pkg

// ### rtl/cic_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module cic_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic push_valid_in,
  output logic push_ready_out,
  input wire logic [WIDTH-1:0] push_data_in,
  output logic pop_valid_out,
  input wire logic pop_ready_in,
  output logic [WIDTH-1:0] pop_data_out
);
  localparam int PW = $clog2(DEPTH);
  // Occupancy at which the writer is held off
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  // Last slot index, pointers wrap after it for any depth
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] cnt_q, cnt_d;
  logic room_q, room_d, empty_q, empty_d;
  logic push, pop;

  assign push = push_valid_in && room_q;
  assign pop = pop_ready_in && !empty_q;
  // Ready comes straight from a register, no logic after it
  assign push_ready_out = room_q;
  assign pop_valid_out = !empty_q;
  assign pop_data_out = mem[rd_q];

  // Pointer and occupancy update
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      wr_d = (wr_q == LAST_PTR) ? '0 : PW'(wr_q + 1'b1);
    end
    if (pop) begin
      rd_d = (rd_q == LAST_PTR) ? '0 : PW'(rd_q + 1'b1);
    end
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (PW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (PW+1)'(cnt_q - 1'b1);
    end
    room_d = (cnt_d != FULL_CNT);
    empty_d = (cnt_d == '0);
  end

  // Pointer and flag registers, empty with room after reset
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      room_q <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      room_q <= room_d;
      empty_q <= empty_d;
    end
  end

  // Storage array, no reset needed
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_q] <= push_data_in;
    end
  end
endmodule : cic_fifo

// ### rtl/cic_interp5.sv
// One channel of the fifth-order interpolator with shift scaling
//
// Overview of operation
// [RULE_01] Samples flow coefficient filter, interpolator, resampler, scaler, tuner. Here the resampler is bypassed.
// [RULE_02] Gain equals factor to fourth, times resampler factor, times 2^-shift.
// [RULE_03] Scale shift is unsigned per channel, accepted from 0 up to 58.
// [RULE_04] Eight-bit channel register holds interpolation factor minus one.
// [RULE_05] Software keeps the interpolation factor between 1 and 32.
// [RULE_06] Each input sample yields factor output samples.
// [RULE_07] Five comb and five integrator sections give moving-sum to fifth power.
// [RULE_08] Channel register holds scale shift used by the scaling stage.
// [RULE_09] Shift picks output bit slice, six dB per step.
// [RULE_10] Software sets shift at least ceil(4log2 L + log2 Lr).
// [RULE_11] Accumulators wide enough never to overflow for factor up to 32.
// [RULE_12] Resampler factor lies in 1..4096, set by the resampler itself.
// [RULE_13] Reset clears every integrator and comb register.
// [RULE_14] Factor one passes each sample once with unity gain.
`timescale 1ns/10ps
module cic_interp5 #(
  parameter int DEPTH = cic_pkg::FIFO_DEPTH
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire cic_pkg::cic_iq_s in_sample_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output cic_pkg::cic_iq_s out_sample_out,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out
);
  localparam int SW = cic_pkg::SAMPLE_W;
  localparam int AW = cic_pkg::ACC_W;
  localparam int N = cic_pkg::ORDER;
  localparam int FW = cic_pkg::FACTOR_W;
  localparam int HW = cic_pkg::SHIFT_W;

  // Channel registers
  logic [FW-1:0] factor_m1_q, factor_m1_d;
  logic [HW-1:0] shift_q, shift_d;
  logic [7:0] rdata_q, rdata_d;

  // Register writes and registered read-back
  always_comb begin
    factor_m1_d = factor_m1_q;
    shift_d = shift_q;
    rdata_d = rdata_q;
    if (cfg_wr_in && cfg_addr_in == cic_pkg::FACTOR_OFS) begin
      factor_m1_d = cfg_wdata_in; // RULE_04
    end
    if (cfg_wr_in && cfg_addr_in == cic_pkg::SHIFT_OFS) begin
      shift_d = cfg_wdata_in[HW-1:0]; // RULE_08 RULE_03
    end
    if (cfg_rd_in) begin
      unique case (cfg_addr_in)
        cic_pkg::FACTOR_OFS: rdata_d = factor_m1_q;
        cic_pkg::SHIFT_OFS: rdata_d = {{(8-HW){1'b0}}, shift_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Register state, cleared by reset
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      factor_m1_q <= cic_pkg::FACTOR_RST;
      shift_q <= cic_pkg::SHIFT_RST;
      rdata_q <= 8'h00;
    end else begin
      factor_m1_q <= factor_m1_d;
      shift_q <= shift_d;
      rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata_out = rdata_q;

  // Input buffer between the coefficient filter and the comb sections
  logic pop_valid, pop;
  cic_pkg::cic_iq_s pop_data;

  cic_fifo #(
    .WIDTH(2 * SW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .push_valid_in(in_valid_in),
    .push_ready_out(in_ready_out),
    .push_data_in(in_sample_in),
    .pop_valid_out(pop_valid),
    .pop_ready_in(pop),
    .pop_data_out(pop_data)
  );

  // Sequencing: one comb update per input, factor integrator steps per input
  logic busy_q, busy_d;
  logic [FW-1:0] phase_q, phase_d;
  logic out_valid_q, out_valid_d;
  logic step, last;

  assign step = busy_q && (!out_valid_q || out_ready_in);
  assign last = (phase_q == factor_m1_q);
  assign pop = pop_valid && (!busy_q || (step && last));

  always_comb begin
    busy_d = busy_q;
    phase_d = phase_q;
    out_valid_d = out_valid_q && !out_ready_in;
    if (step) begin
      out_valid_d = 1'b1;
      phase_d = last ? '0 : FW'(phase_q + 1'b1); // RULE_06
      busy_d = !last;
    end
    if (pop) begin
      busy_d = 1'b1;
      phase_d = '0;
    end
  end

  // Sequencer state, idle after reset
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_q <= 1'b0;
      phase_q <= '0;
      out_valid_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      phase_q <= phase_d;
      out_valid_q <= out_valid_d;
    end
  end

  // Valid comes straight from its register
  assign out_valid_out = out_valid_q;

  // Scaled lane results, index 0 is I and 1 is Q
  logic signed [SW-1:0] scaled [2];

  // Per-lane comb and integrator cascade
  for (genvar g = 0; g < 2; g++) begin : g_lane
    logic signed [AW-1:0] dly_q [N];
    logic signed [AW-1:0] dly_d [N];
    logic signed [AW-1:0] intg_q [N];
    logic signed [AW-1:0] intg_d [N];
    logic signed [AW-1:0] comb_q, comb_d;
    logic signed [SW-1:0] raw;
    logic signed [AW-1:0] wide;

    // Lane 0 carries I, lane 1 carries Q
    assign raw = (g == 0) ? pop_data.i : pop_data.q;

    // Combs at input rate, zero-stuffed integrators at output rate
    always_comb begin
      logic signed [AW-1:0] c;
      logic signed [AW-1:0] s;
      c = {{(AW-SW){raw[SW-1]}}, raw}; // RULE_11
      s = '0;
      dly_d = dly_q;
      comb_d = comb_q;
      intg_d = intg_q;
      if (pop) begin
        for (int k = 0; k < N; k++) begin
          dly_d[k] = c;
          c = c - dly_q[k]; // RULE_07
        end
        comb_d = c;
      end
      if (step) begin
        s = (phase_q == '0) ? comb_q : '0; // RULE_14
        for (int k = 0; k < N; k++) begin
          intg_d[k] = intg_q[k] + s; // RULE_07
          s = intg_d[k];
        end
      end
      wide = intg_d[N-1] >>> shift_q; // RULE_09 RULE_02
    end

    // Lane state, cleared so filtering restarts from zero
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        for (int k = 0; k < N; k++) begin
          dly_q[k] <= '0; // RULE_13
          intg_q[k] <= '0; // RULE_13
        end
        comb_q <= '0;
      end else begin
        dly_q <= dly_d;
        intg_q <= intg_d;
        comb_q <= comb_d;
      end
    end

    assign scaled[g] = wide[SW-1:0];
  end

  // Output register, resampler stage bypassed so scaling follows directly
  cic_pkg::cic_iq_s out_q, out_d;

  always_comb begin
    out_d = out_q;
    if (step) begin
      out_d.i = scaled[0]; // RULE_01
      out_d.q = scaled[1];
    end
  end

  // Output register holds the sample until it is taken
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign out_sample_out = out_q;
endmodule : cic_interp5

// ### tb/cic_interp5_monitor.sv
// Port checker for the fifth-order interpolator
`timescale 1ns/10ps
module cic_interp5_monitor (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  input wire logic in_ready_out,
  input wire logic out_valid_out,
  input wire logic out_ready_in,
  input wire cic_pkg::cic_iq_s out_sample_out,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic [7:0] cfg_rdata_out
);
  logic pushed_q;
  // Remembers that a sample entered since reset
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) pushed_q <= 1'b0;
    else if (in_valid_in && in_ready_out) pushed_q <= 1'b1;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_rst_vals;
    $past(sys_rst_in) |-> in_ready_out && !out_valid_out
      && cfg_rdata_out == 8'h00;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("state not cleared after reset");
  property p_shift_rb;
    cfg_wr_in && cfg_addr_in == 8'h06 ##1 cfg_rd_in && !cfg_wr_in
      && cfg_addr_in == 8'h06 |=>
      cfg_rdata_out == ($past(cfg_wdata_in, 2) & 8'h3f);
  endproperty
  a_shift_rb: assert property (p_shift_rb)
    else $error("shift readback wrong");
  property p_fact_rb;
    cfg_wr_in && cfg_addr_in == 8'h09 ##1 cfg_rd_in && !cfg_wr_in
      && cfg_addr_in == 8'h09 |=> cfg_rdata_out == $past(cfg_wdata_in, 2);
  endproperty
  a_fact_rb: assert property (p_fact_rb)
    else $error("factor readback wrong");
  property p_unmapped;
    cfg_rd_in && cfg_addr_in != 8'h06 && cfg_addr_in != 8'h09
      |=> cfg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_rd_hold;
    !cfg_rd_in |=> $stable(cfg_rdata_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without read");
  property p_out_hold;
    out_valid_out && !out_ready_in |=> out_valid_out;
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output dropped while stalled");
  property p_data_hold;
    out_valid_out && !out_ready_in |=> $stable(out_sample_out);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("output data changed while stalled");
  property p_ready_fall;
    $fell(in_ready_out) |-> $past(in_valid_in);
  endproperty
  a_ready_fall: assert property (p_ready_fall)
    else $error("buffer filled without a push");
  property p_first_out;
    $rose(out_valid_out) |-> pushed_q;
  endproperty
  a_first_out: assert property (p_first_out)
    else $error("output without any input");
  c_full: cover property ($fell(in_ready_out));
  c_take: cover property (out_valid_out && out_ready_in);
  c_stall: cover property (out_valid_out && !out_ready_in);
endmodule : cic_interp5_monitor

bind cic_interp5 cic_interp5_monitor MON (.core_clk_in, .sys_rst_in,
  .in_valid_in, .in_ready_out, .out_valid_out, .out_ready_in,
  .out_sample_out, .cfg_wr_in, .cfg_rd_in, .cfg_addr_in, .cfg_wdata_in,
  .cfg_rdata_out);

// ### tb/cic_sink.sv
// Tuner-side sink that logs output samples and can stall
`timescale 1ns/10ps
module cic_sink (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic valid_in,
  input wire cic_pkg::cic_iq_s sample_in,
  input wire logic stall_in,
  output logic ready_out
);
  cic_pkg::cic_iq_s q[$];
  // Accepts whenever not told to stall
  assign ready_out = !stall_in;
  // Logs each taken sample, resampler bypassed at every factor
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) q.delete();
    else if (valid_in && ready_out) q.push_back(sample_in);
  end
endmodule : cic_sink

// ### tb/cic_interp5_bench.sv
// Self-checking bench for the fifth-order interpolator
`timescale 1ns/10ps
module cic_interp5_bench;
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic in_valid_in = 1'b0;
  logic cfg_wr_in = 1'b0;
  logic cfg_rd_in = 1'b0;
  logic stall = 1'b0;
  logic out_ready_in, out_valid_out, in_ready_out;
  logic [7:0] cfg_addr_in = 8'h00;
  logic [7:0] cfg_wdata_in = 8'h00;
  logic [7:0] cfg_rdata_out;
  cic_pkg::cic_iq_s in_sample_in = '0;
  cic_pkg::cic_iq_s out_sample_out;
  int err_count = 0;
  int n_checks = 0;
  always #25 core_clk_in = ~core_clk_in;
  cic_interp5 DUT (.core_clk_in, .sys_rst_in, .in_valid_in, .in_ready_out,
    .in_sample_in, .out_valid_out, .out_ready_in, .out_sample_out,
    .cfg_wr_in, .cfg_rd_in, .cfg_addr_in, .cfg_wdata_in, .cfg_rdata_out);
  cic_sink SNK (.core_clk_in, .sys_rst_in, .valid_in(out_valid_out),
    .sample_in(out_sample_out), .stall_in(stall), .ready_out(out_ready_in));
  task chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task report_and_stop;
    $display("Checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task do_reset;
    sys_rst_in <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
  endtask : do_reset
  // Two writes back to back, strobe held across both
  task wr2(input logic [7:0] a1, d1, a2, d2);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a1;
    cfg_wdata_in <= d1;
    @(posedge core_clk_in);
    cfg_addr_in <= a2;
    cfg_wdata_in <= d2;
    @(posedge core_clk_in);
    cfg_wr_in <= 1'b0;
  endtask : wr2
  task rd(input logic [7:0] a, exp);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge core_clk_in);
    cfg_rd_in <= 1'b0;
    @(negedge core_clk_in);
    chk("rdata", {24'h0, cfg_rdata_out}, {24'h0, exp});
    @(posedge core_clk_in);
  endtask : rd
  // Reset values, readback, shift field width, unmapped places
  task t_regs;
    rd(8'h06, 8'h00);
    rd(8'h09, 8'h00);
    wr2(8'h07, 8'h55, 8'h06, 8'hfa);
    rd(8'h06, 8'h3a);
    wr2(8'h00, 8'haa, 8'h09, 8'h1f);
    rd(8'h09, 8'h1f);
    rd(8'h07, 8'h00);
    $display("Test regs done");
  endtask : t_regs
  // Steady input level; counts outputs and checks settled gain
  task t_dc(input logic [7:0] fm1, sh, int n, input logic [15:0] c, e);
    int k;
    do_reset;
    wr2(8'h06, sh, 8'h09, fm1);
    for (k = 0; k < n; k++) begin
      in_valid_in <= 1'b1;
      in_sample_in <= {c, c};
      do @(negedge core_clk_in); while (!in_ready_out);
      @(posedge core_clk_in);
    end
    in_valid_in <= 1'b0;
    for (k = 0; k < 3000 && SNK.q.size() < n * (fm1 + 1); k++)
      @(posedge core_clk_in);
    repeat (8) @(posedge core_clk_in);
    chk("count", SNK.q.size(), n * (fm1 + 1));
    chk("last", SNK.q[$], {e, e});
    $display("Test dc done");
  endtask : t_dc
  // Fill the buffer under stall, then drain full-scale samples
  task t_fill;
    int acc;
    int k;
    acc = 0;
    do_reset;
    wr2(8'h06, 8'h14, 8'h09, 8'h1f);
    stall <= 1'b1;
    for (k = 0; k < 40; k++) begin
      in_valid_in <= 1'b1;
      in_sample_in <= 32'h7fff7fff;
      @(negedge core_clk_in);
      if (in_ready_out) acc++;
      @(posedge core_clk_in);
    end
    in_valid_in <= 1'b0;
    @(negedge core_clk_in);
    chk("ready", in_ready_out, 1'b0);
    chk("fill", acc, cic_pkg::FIFO_DEPTH + 1);
    @(posedge core_clk_in);
    stall <= 1'b0;
    for (k = 0; k < 3000 && SNK.q.size() < acc * 32; k++)
      @(posedge core_clk_in);
    repeat (8) @(posedge core_clk_in);
    chk("drain", SNK.q.size(), acc * 32);
    chk("full", SNK.q[$], 32'h7fff7fff);
    $display("Test fill done");
  endtask : t_fill
  initial begin
    do_reset;
    t_regs;
    t_dc(8'h00, 8'h00, 1, 16'h1234, 16'h1234);
    t_dc(8'h01, 8'h04, 8, 16'h0064, 16'h0064);
    t_dc(8'h01, 8'h05, 8, 16'h0064, 16'h0032);
    t_fill;
    report_and_stop;
  end
  // Cuts a hang short
  initial begin
    #(10000 * 50);
    err_count++;
    $display("ERROR watchdog expired");
    report_and_stop;
  end
endmodule : cic_interp5_bench
